// *** logic/dsp_pkg.sv ***
/*
  Shared constants for the double-data-rate memory physical layer.
  Assumes a single 20 MHz fabric clock and a memory clock of a quarter of it.
*/
`default_nettype none
package dsp_pkg;
  // ****************************************
  // Group layout
  // ****************************************
  localparam int GRP_W = 8;
  localparam int DATA_GRPS = 2;
  // One extra group carries the check bits
  // extra ECC group
  localparam int ECC_GRPS = 1;
  localparam int NGRP = DATA_GRPS + ECC_GRPS;
  localparam int DW = NGRP * GRP_W;
  localparam int AW = 13;

  // ****************************************
  // Memory clock quarter phases
  // ****************************************
  localparam logic [1:0] PH_CK_RISE = 2'h0;
  localparam logic [1:0] PH_ACC = 2'h1;
  localparam logic [1:0] PH_CK_FALL = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ****************************************
  // Read strobe shift
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int RD_SHIFT_NS = LINK_PERIOD_NS / 4;
  localparam int RD_SHIFT_RAW = (RD_SHIFT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_SHIFT_CYC = (RD_SHIFT_RAW < 1) ? 1 : RD_SHIFT_RAW;

  typedef enum logic {DSP_IDLE, DSP_WR} dsp_state_e;
endpackage
`default_nettype wire

// *** logic/dsp_phy.sv ***
/*
  Physical layer between a memory controller and a DDR/DDR2 SDRAM
  or a burst-of-two/four quad-data-rate SRAM.
  Assumes strobes, echo clocks and read data arrive asynchronously;
  mode inputs are static and come from logic on ref_clk.
*/
// Functional notes
// - Commands and addresses launch for the rising edge, except the burst-of-two SRAM write address; data uses both edges.
// - Only the true strobe captures SDRAM reads; complementary strobe unused.
// - Wide memories are built from eight-bit groups, one per strobe.
// - Each group has one active-high write mask, driven during SDRAM writes.
// - Error correction adds one more group for check bits.
// - Commands and addresses launch from the falling memory clock edge, except the burst-of-two SRAM write address.
// - Memory clock from output registers; write strobe rises within a quarter.
// - Received strobe is delayed a quarter cycle to centre it in data.
// - Write strobe on zero phase, write data a quarter earlier.
// - SRAM reads and writes may proceed concurrently on separate ports.
// - Burst-of-two SRAM: read address for rising, write for falling edge.
// - Burst-of-four SRAM: both addresses sampled on the rising edge.
// - SRAM single-clock mode: input clock pair driven, output pair unused.
// - Echo clock output enables held off; never driven.
// - True echo clocks three capture registers, complementary echo the fourth.
// - SRAM write data from write clock; input clock a quarter later.
// - Every complementary clock is the inverse of its true clock.
`timescale 1ns/1ps
`default_nettype none
module dsp_phy (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sram_mode,
  input wire logic sram_burst4,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic [2:0] cmd_code,
  input wire logic [dsp_pkg::AW-1:0] rd_addr,
  input wire logic [dsp_pkg::AW-1:0] wr_addr,
  input wire logic [dsp_pkg::DW-1:0] wr_lo,
  input wire logic [dsp_pkg::DW-1:0] wr_hi,
  input wire logic [dsp_pkg::NGRP-1:0] wr_mask_lo,
  input wire logic [dsp_pkg::NGRP-1:0] wr_mask_hi,
  output logic rd_valid,
  output logic [dsp_pkg::DW-1:0] rd_lo,
  output logic [dsp_pkg::DW-1:0] rd_hi,
  output logic mem_ck,
  output logic mem_ck_n,
  output logic [2:0] mem_cmd,
  output logic [dsp_pkg::AW-1:0] mem_addr,
  input wire logic [dsp_pkg::DW-1:0] dq_i,
  output logic [dsp_pkg::DW-1:0] dq_o,
  output logic dq_oe_n,
  output logic [dsp_pkg::NGRP-1:0] dm,
  input wire logic [dsp_pkg::NGRP-1:0] dqs_i,
  output logic [dsp_pkg::NGRP-1:0] dqs_o,
  output logic dqs_oe_n,
  output logic [dsp_pkg::DW-1:0] sram_d,
  output logic sram_k,
  output logic sram_k_n,
  input wire logic strobe_echo_true_pin_i,
  output logic strobe_echo_true_pin_o,
  output logic strobe_echo_true_pin_oe_n,
  input wire logic strobe_echo_comp_pin_i,
  output logic strobe_echo_comp_pin_o,
  output logic strobe_echo_comp_pin_oe_n
);
  import dsp_pkg::*;

  localparam int SW = NGRP + 2;
  localparam int EW = 2 * NGRP + 1;
  // Complement echo idles high; resetting to pin idle avoids a false edge
  localparam logic [SW-1:0] SYNC_IDLE = {1'b1, {(SW-1){1'b0}}};

  // ****************************************
  // Launch side
  // ****************************************
  logic [1:0] ph_r, ph_nxt;
  dsp_state_e st_r, st_nxt;
  logic [DW-1:0] wlo_r, wlo_nxt, whi_r, whi_nxt;
  logic [NGRP-1:0] mlo_r, mlo_nxt, mhi_r, mhi_nxt;
  logic [AW-1:0] wa_r, wa_nxt, addr_r, addr_nxt;
  logic wp_r, wp_nxt, ck_r, ck_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [DW-1:0] dq_r, dq_nxt, sd_r, sd_nxt;
  logic [NGRP-1:0] dm_r, dm_nxt, dqs_r, dqs_nxt;
  logic oe_n_r, oe_n_nxt;
  logic accept, wact, lo_beat;

  // Accept only one quarter before the falling memory edge
  assign cmd_ready = (ph_r == PH_ACC) && !sys_rst;
  assign accept = cmd_valid && cmd_ready;
  assign wact = (st_r == DSP_WR);
  assign lo_beat = (ph_nxt == PH_LAST) || (ph_nxt == PH_CK_RISE);

  // Next values of phase, commands and write pins
  always_comb begin
    ph_nxt = ph_r + 2'h1;
    st_nxt = st_r;
    wlo_nxt = wlo_r;
    whi_nxt = whi_r;
    mlo_nxt = mlo_r;
    mhi_nxt = mhi_r;
    wa_nxt = wa_r;
    wp_nxt = wp_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    ck_nxt = ph_nxt < PH_CK_FALL;
    if (accept && cmd_wr) begin
      st_nxt = DSP_WR;
    end else if (wact && ph_r == PH_ACC) begin
      st_nxt = DSP_IDLE;
    end
    if (accept) begin
      wlo_nxt = wr_lo;
      whi_nxt = wr_hi;
      mlo_nxt = wr_mask_lo;
      mhi_nxt = wr_mask_hi;
      wa_nxt = wr_addr;
    end
    if (ph_r == PH_ACC) begin
      cmd_nxt = CMD_NOP;
      if (accept) begin
        cmd_nxt = sram_mode ? {1'b1, ~cmd_wr, ~cmd_rd} : cmd_code;
        addr_nxt = cmd_rd ? rd_addr : wr_addr;
        wp_nxt = sram_mode && !sram_burst4 && cmd_wr;
      end
    end
    if (ph_r == PH_LAST && wp_r) begin
      addr_nxt = wa_r;
      wp_nxt = 1'b0;
    end
    dq_nxt = dq_r;
    sd_nxt = sd_r;
    dm_nxt = '0;
    dqs_nxt = '0;
    oe_n_nxt = 1'b1;
    if (wact) begin
      if (sram_mode) begin
        sd_nxt = lo_beat ? wlo_r : whi_r;
      end else begin
        dq_nxt = lo_beat ? wlo_r : whi_r;
        dm_nxt = lo_beat ? mlo_r : mhi_r;
        dqs_nxt = {NGRP{ph_nxt < PH_CK_FALL}};
        oe_n_nxt = 1'b0;
      end
    end
  end

  // Launch registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ph_r <= PH_CK_RISE;
      st_r <= DSP_IDLE;
      wlo_r <= '0;
      whi_r <= '0;
      mlo_r <= '0;
      mhi_r <= '0;
      wa_r <= '0;
      wp_r <= 1'b0;
      cmd_r <= CMD_NOP;
      addr_r <= '0;
      ck_r <= 1'b0;
      dq_r <= '0;
      sd_r <= '0;
      dm_r <= '0;
      dqs_r <= '0;
      oe_n_r <= 1'b1;
    end else begin
      ph_r <= ph_nxt;
      st_r <= st_nxt;
      wlo_r <= wlo_nxt;
      whi_r <= whi_nxt;
      mlo_r <= mlo_nxt;
      mhi_r <= mhi_nxt;
      wa_r <= wa_nxt;
      wp_r <= wp_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      ck_r <= ck_nxt;
      dq_r <= dq_nxt;
      sd_r <= sd_nxt;
      dm_r <= dm_nxt;
      dqs_r <= dqs_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // Pin outputs
  // complements by inversion
  assign mem_ck = ck_r;
  assign mem_ck_n = ~ck_r;
  assign sram_k = ck_r;
  assign sram_k_n = ~ck_r;
  assign mem_cmd = cmd_r;
  assign mem_addr = addr_r;
  assign dq_o = dq_r;
  assign dq_oe_n = oe_n_r;
  assign dm = dm_r;
  assign dqs_o = dqs_r;
  assign dqs_oe_n = oe_n_r;
  assign sram_d = sd_r;
  assign strobe_echo_true_pin_o = 1'b0;
  assign strobe_echo_true_pin_oe_n = 1'b1;
  assign strobe_echo_comp_pin_o = 1'b0;
  assign strobe_echo_comp_pin_oe_n = 1'b1;

  // ****************************************
  // Read capture side
  // ****************************************
  logic [SW-1:0] s1_r, s2_r, s3_r;
  logic [DW-1:0] d1_r, d2_r;
  logic [EW-1:0] dl_r [RD_SHIFT_CYC];
  logic [EW-1:0] dl_nxt [RD_SHIFT_CYC];
  logic [NGRP-1:0] rise, fall, dr, df;
  logic crise, dc;
  logic [DW-1:0] a_r, a_nxt, b_r, b_nxt, lo_r, lo_nxt, hi_r, hi_nxt;
  logic vld_r, vld_nxt, hv_r, hv_nxt;

  // Edges per group; SDRAM sees only its true strobe
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      rise[g] = sram_mode ? (s2_r[NGRP] && !s3_r[NGRP]) : (s2_r[g] && !s3_r[g]);
      fall[g] = sram_mode ? (!s2_r[NGRP] && s3_r[NGRP]) : (!s2_r[g] && s3_r[g]);
    end
    crise = s2_r[NGRP+1] && !s3_r[NGRP+1];
  end

  always_comb begin
    dl_nxt[0] = {crise, fall, rise};
    for (int i = 1; i < RD_SHIFT_CYC; i++) begin
      dl_nxt[i] = dl_r[i-1];
    end
  end

  assign dr = dl_r[RD_SHIFT_CYC-1][NGRP-1:0];
  assign df = dl_r[RD_SHIFT_CYC-1][2*NGRP-1:NGRP];
  assign dc = dl_r[RD_SHIFT_CYC-1][2*NGRP];

  // Capture; data sampled mid-eye since strobe edges trail data by RD_SHIFT_CYC cycles after the shared sync
  always_comb begin
    a_nxt = a_r;
    b_nxt = b_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    hv_nxt = hv_r;
    vld_nxt = 1'b0;
    if (sram_mode) begin
      if (dc) begin
        b_nxt = d2_r;
      end
      if (dr[0]) begin
        a_nxt = d2_r;
        lo_nxt = a_r;
        hi_nxt = b_r;
        vld_nxt = hv_r;
      end
      // Pair is complete once B has caught its word
      hv_nxt = dc ? 1'b1 : (dr[0] ? 1'b0 : hv_r);
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        if (dr[g]) begin
          a_nxt[g*GRP_W +: GRP_W] = d2_r[g*GRP_W +: GRP_W];
        end
        if (df[g]) begin
          lo_nxt[g*GRP_W +: GRP_W] = a_r[g*GRP_W +: GRP_W];
          hi_nxt[g*GRP_W +: GRP_W] = d2_r[g*GRP_W +: GRP_W];
        end
      end
      vld_nxt = df[0];
    end
  end

  // Capture registers; first stage only feeds the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
      s3_r <= SYNC_IDLE;
      d1_r <= '0;
      d2_r <= '0;
      for (int i = 0; i < RD_SHIFT_CYC; i++) begin
        dl_r[i] <= '0;
      end
      a_r <= '0;
      b_r <= '0;
      lo_r <= '0;
      hi_r <= '0;
      hv_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      s1_r <= {strobe_echo_comp_pin_i, strobe_echo_true_pin_i, dqs_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      d1_r <= dq_i;
      d2_r <= d1_r;
      for (int i = 0; i < RD_SHIFT_CYC; i++) begin
        dl_r[i] <= dl_nxt[i];
      end
      a_r <= a_nxt;
      b_r <= b_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      hv_r <= hv_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign rd_valid = vld_r;
  assign rd_lo = lo_r;
  assign rd_hi = hi_r;

  // ****************************************
  // Checks
  // ****************************************
  AST_CMD_EDGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(mem_cmd) |-> $past(ph_r) == PH_ACC)
    else $error("command changed off its launch phase");
  AST_ADDR_LAUNCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(mem_addr) |-> ($past(ph_r) == PH_ACC || $past(ph_r) == PH_LAST))
    else $error("address changed at an illegal phase");
  AST_B4_ADDR: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sram_burst4 && $changed(mem_addr) |-> $past(ph_r) == PH_ACC)
    else $error("burst-of-four address not for rising edge");
  AST_DQS_CK: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(dqs_o[0]) |-> mem_ck && ph_r == PH_CK_RISE)
    else $error("write strobe rise not aligned to clock");
  AST_DQ_QUARTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(dq_o) |-> (ph_r == PH_LAST || ph_r == PH_ACC) && !dq_oe_n)
    else $error("write data moved off the quarter phase");
  AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (|dm) |-> !dq_oe_n && !sram_mode)
    else $error("mask driven outside an SDRAM write");
  AST_ECHO_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    strobe_echo_true_pin_oe_n && strobe_echo_comp_pin_oe_n)
    else $error("echo clock pin enabled");
  AST_INVERSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mem_ck_n == ~mem_ck && sram_k_n == ~sram_k)
    else $error("complement clock not inverted");
  AST_K_SHIFT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(sram_d) |-> ##1 $rose(sram_k) || $fell(sram_k))
    else $error("input clock not a quarter after write data");
  AST_RD_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
endmodule
`default_nettype wire

// *** verification/dsp_mem_model.sv ***
/*
  Far-side memory model: plays read bursts onto strobe or echo pins.
  Assumes the bench pulses one start line per burst; link period 400 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module dsp_mem_model
  import dsp_pkg::*;
(
  input wire logic start_sd,
  input wire logic start_qdr,
  input wire logic [dsp_pkg::DW-1:0] w0,
  input wire logic [dsp_pkg::DW-1:0] w1,
  output logic [dsp_pkg::DW-1:0] dq,
  output logic [dsp_pkg::NGRP-1:0] dqs,
  output logic cq,
  output logic cq_n
);
  logic burst_sd;

  // One process owns every pin; clocks stand still between bursts
  initial begin
    dq = '0;
    dqs = '0;
    cq = 1'b0;
    cq_n = 1'b1;
    burst_sd = 1'b0;
    forever begin
      @(posedge start_sd or posedge start_qdr);
      burst_sd = start_sd;
      // Land off the fabric clock edges so pins and samplers never race
      #10;
      if (burst_sd) begin
        dqs = '1;
        dq = w0;
        #200;
        dqs = '0;
        dq = w1;
        #200;
        dq = ~w1; // Released bus shows garbage
      end else begin
        cq = 1'b1;
        cq_n = 1'b0;
        dq = w0;
        #200;
        cq = 1'b0;
        cq_n = 1'b1;
        dq = w1;
        #200;
        cq = 1'b1;
        cq_n = 1'b0;
        dq = ~w1;
        #200;
        cq = 1'b0;
        cq_n = 1'b1;
        dq = w1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_ddr_sram_memory_phy.sv ***
/*
  Bench for the memory physical layer: write walks, reads, SRAM address edges.
  Assumes dsp_mem_model as far side and a 20 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_sram_memory_phy;
  import dsp_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sram_mode = 1'b0;
  logic sram_burst4 = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_rd = 1'b0;
  logic cmd_wr = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic [AW-1:0] rd_addr = '0;
  logic [AW-1:0] wr_addr = '0;
  logic [DW-1:0] wr_lo = '0;
  logic [DW-1:0] wr_hi = '0;
  logic [NGRP-1:0] wr_mask_lo = '0;
  logic [NGRP-1:0] wr_mask_hi = '0;
  logic start_sd = 1'b0;
  logic start_qdr = 1'b0;
  logic [DW-1:0] pw0 = 24'hC3_A55A;
  logic [DW-1:0] pw1 = 24'h3C_5AA5;
  logic cmd_ready, rd_valid, mem_ck, mem_ck_n, dq_oe_n, dqs_oe_n, sram_k, sram_k_n;
  logic strobe_echo_true_pin_i, strobe_echo_true_pin_o, strobe_echo_true_pin_oe_n;
  logic strobe_echo_comp_pin_i, strobe_echo_comp_pin_o, strobe_echo_comp_pin_oe_n;
  logic [2:0] mem_cmd;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] rd_lo, rd_hi, dq_i, dq_o, sram_d;
  logic [NGRP-1:0] dm, dqs_i, dqs_o;
  int failures = 0;
  int check_count = 0;

  // ****************************************
  // Clock, design and far side
  // ****************************************
  always #25 ref_clk = ~ref_clk;

  dsp_phy dut (.ref_clk, .sys_rst, .sram_mode, .sram_burst4, .cmd_valid, .cmd_ready,
    .cmd_rd, .cmd_wr, .cmd_code, .rd_addr, .wr_addr, .wr_lo, .wr_hi, .wr_mask_lo,
    .wr_mask_hi, .rd_valid, .rd_lo, .rd_hi, .mem_ck, .mem_ck_n, .mem_cmd, .mem_addr,
    .dq_i, .dq_o, .dq_oe_n, .dm, .dqs_i, .dqs_o, .dqs_oe_n, .sram_d, .sram_k, .sram_k_n,
    .strobe_echo_true_pin_i, .strobe_echo_true_pin_o, .strobe_echo_true_pin_oe_n,
    .strobe_echo_comp_pin_i, .strobe_echo_comp_pin_o, .strobe_echo_comp_pin_oe_n);

  dsp_mem_model far (.start_sd, .start_qdr, .w0(pw0), .w1(pw1), .dq(dq_i), .dqs(dqs_i),
    .cq(strobe_echo_true_pin_i), .cq_n(strobe_echo_comp_pin_i));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Holds the request until the accepting edge; returns in the cycle after it
  task automatic req(input logic rd, input logic wr, input logic [2:0] code,
      input logic [AW-1:0] ra, input logic [AW-1:0] wa, input logic [DW-1:0] lo,
      input logic [DW-1:0] hi, input logic [NGRP-1:0] ml, input logic [NGRP-1:0] mh);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_rd <= rd;
    cmd_wr <= wr;
    cmd_code <= code;
    rd_addr <= ra;
    wr_addr <= wa;
    wr_lo <= lo;
    wr_hi <= hi;
    wr_mask_lo <= ml;
    wr_mask_hi <= mh;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic mode(input logic m, input logic b4);
    @(posedge ref_clk);
    sram_mode <= m;
    sram_burst4 <= b4;
    repeat (8) @(posedge ref_clk);
  endtask

  // Bounded wait for the read pulse, sampled mid-cycle
  task automatic wait_rd;
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    cmp(rd_valid, 1'b1);
  endtask

  // Pin relations that must hold every cycle out of reset
  always @(negedge ref_clk) begin
    if (sys_rst === 1'b0) begin
      cmp(mem_ck ^ mem_ck_n, 1'b1);
      cmp(sram_k ^ sram_k_n, 1'b1);
      cmp(sram_k, mem_ck);
      cmp({strobe_echo_true_pin_oe_n, strobe_echo_comp_pin_oe_n, strobe_echo_true_pin_o,
        strobe_echo_comp_pin_o}, 4'hC);
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    repeat (12) @(negedge ref_clk);
    cmp({cmd_ready, rd_valid, dq_oe_n, mem_cmd}, 6'h0F);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    $display("reset test done");
  endtask

  task automatic t_sd_write;
    req(1'b0, 1'b1, 3'h4, 13'h0ABC, 13'h0ABC, 24'h12_3456, 24'hFE_DCBA, 3'h5, 3'h2);
    cmp(mem_cmd, 3'h4);
    cmp(mem_addr, 13'h0ABC);
    @(negedge ref_clk);
    cmp(dq_o, 24'h12_3456);
    cmp({dm, dq_oe_n, dqs_oe_n}, 5'h14);
    @(negedge ref_clk);
    cmp({dqs_o, mem_ck}, 4'hF);
    cmp(dqs_o, {NGRP{1'b1}});
    @(negedge ref_clk);
    cmp(dq_o, 24'hFE_DCBA);
    cmp(dm, 3'h2);
    @(negedge ref_clk);
    cmp({dqs_o, mem_ck, mem_cmd}, 7'h07);
    @(negedge ref_clk);
    cmp({dq_oe_n, dm}, 4'h8);
    $display("sdram write test done");
  endtask

  task automatic t_sd_read;
    @(posedge ref_clk);
    start_sd <= 1'b1;
    @(posedge ref_clk);
    start_sd <= 1'b0;
    wait_rd;
    cmp(rd_lo, 24'hC3_A55A);
    cmp(rd_hi, 24'h3C_5AA5);
    cmp(rd_hi[DW-1 -: GRP_W], 8'h3C);
    $display("sdram read test done");
  endtask

  task automatic t_qdr_write;
    mode(1'b1, 1'b0);
    req(1'b1, 1'b1, 3'h0, 13'h0ABC, 13'h1234, 24'h00_FF0F, 24'h5A_0033, 3'h0, 3'h0);
    cmp(mem_cmd, 3'h4);
    cmp(mem_addr, 13'h0ABC);
    @(negedge ref_clk);
    cmp(sram_d, 24'h00_FF0F);
    @(negedge ref_clk);
    cmp({mem_addr, sram_k}, {13'h1234, 1'b1});
    @(negedge ref_clk);
    cmp(sram_d, 24'h5A_0033);
    $display("sram burst2 test done");
  endtask

  task automatic t_qdr_b4;
    mode(1'b1, 1'b1);
    req(1'b1, 1'b0, 3'h0, 13'h0777, 13'h1555, 24'h0, 24'h0, 3'h0, 3'h0);
    cmp(mem_cmd, 3'h6);
    @(negedge ref_clk);
    @(negedge ref_clk);
    cmp(mem_addr, 13'h0777);
    $display("sram burst4 test done");
  endtask

  task automatic t_qdr_read;
    @(posedge ref_clk);
    start_qdr <= 1'b1;
    @(posedge ref_clk);
    start_qdr <= 1'b0;
    wait_rd;
    cmp(rd_lo, 24'hC3_A55A);
    cmp(rd_hi, 24'h3C_5AA5);
    $display("sram read test done");
  endtask

  // Runs end here or at the watchdog; the tests need about 4 us
  initial begin
    #100000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test;
  end

  initial begin
    t_reset;
    t_sd_write;
    t_sd_read;
    t_qdr_write;
    t_qdr_b4;
    t_qdr_read;
    stop_test;
  end
endmodule
`default_nettype wire
